// *** inc/ascp_pkg.sv ***
// What this block does
// - Page selector at local address 0x01 of every page; reads back current page.
// - Read-only 16-bit base part number, one decimal digit per nibble, two bytes.
// - Read-only grade register: 0=A, 1=B, 2=C, 3=D.
// - Read-only revision register counts letters from zero: 0=A, 1=B.
// - Read-only image version: special, revision, image_version_high fields.
// - Writable 7-bit bus target address, default 0x6C, excluded from NVM saves.
// - Internal status: calibrating bit0, crystal lost bit1, crystal error bit3, timeout bit5.
// - Internal status bits 7:6 report loss on the two auxiliary inputs.
// - Live per-input loss-of-signal bits 3:0, out-of-frequency bits 7:4.
// - Live per-PLL unlock bits 3:0, holdover bits 7:4, PLL A lowest.
// - Calibration status bits 7:4 show each PLL busy calibrating.
// - Internal error flags latch on status, clear by writing zero to the bit.
// - Sticky input loss/frequency flags, same layout, cleared only by writing zero.
// - Sticky PLL unlock and holdover flags, same layout as live register.
// - Sticky PLL calibration-busy flags in bits 7:4.
// - Internal error mask bit 1 blocks interrupt; default 0x35.
// - Input alarm mask bit 1 blocks matching sticky flag from interrupting.
// - PLL mask bits block sticky unlock (3:0) and holdover (7:4) flags.
// - Calibration mask bits 7:4 block sticky calibration flags.
// - Writing 1 to device soft reset resets, calibrates, reloads bandwidth, aligns.
// - Per-PLL soft reset resets one PLL only; reference PLL bit affects all.
// - Rising edge on step-up or step-down bit steps permitted feedback dividers.
// - Device-ready status readable at 0xFE on every page.
package ascp_pkg;

  // ****************************************************************
  // Register offsets (local byte address within page zero)
  // ****************************************************************
  localparam logic [7:0] ADDR_PAGE_SELECT = 8'h01;
  localparam logic [7:0] ADDR_PART_LOW = 8'h02;
  localparam logic [7:0] ADDR_PART_HIGH = 8'h03;
  localparam logic [7:0] ADDR_SPEED_GRADE = 8'h04;
  localparam logic [7:0] ADDR_SILICON_REV = 8'h05;
  localparam logic [7:0] ADDR_IMAGE_LOW = 8'h06;
  localparam logic [7:0] ADDR_IMAGE_MINOR = 8'h07;
  localparam logic [7:0] ADDR_IMAGE_HIGH = 8'h08;
  localparam logic [7:0] ADDR_TEMP_GRADE = 8'h09;
  localparam logic [7:0] ADDR_PACKAGE_CODE = 8'h0A;
  localparam logic [7:0] ADDR_BUS_TARGET = 8'h0B;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_INPUT_STATUS = 8'h0D;
  localparam logic [7:0] ADDR_PLL_STATUS = 8'h0E;
  localparam logic [7:0] ADDR_CAL_STATUS = 8'h0F;
  localparam logic [7:0] ADDR_INT_FLAGS = 8'h11;
  localparam logic [7:0] ADDR_INPUT_FLAGS = 8'h12;
  localparam logic [7:0] ADDR_PLL_FLAGS = 8'h13;
  localparam logic [7:0] ADDR_CAL_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_HOLD_CFG = 8'h16;
  localparam logic [7:0] ADDR_INT_MASKS = 8'h17;
  localparam logic [7:0] ADDR_INPUT_MASKS = 8'h18;
  localparam logic [7:0] ADDR_PLL_MASKS = 8'h19;
  localparam logic [7:0] ADDR_CAL_MASKS = 8'h1A;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h1C;
  localparam logic [7:0] ADDR_FREQ_STEP = 8'h1D;
  localparam logic [7:0] ADDR_DEVICE_READY = 8'hFE;

  // ****************************************************************
  // Field positions and implemented-bit masks
  // ****************************************************************
  localparam int BIT_SOFT_ALL = 0;
  localparam int BIT_SOFT_PLL_A = 1;
  localparam int BIT_SOFT_REF_PLL = 2;
  localparam int BIT_STEP_UP = 0;
  localparam int BIT_STEP_DOWN = 1;
  localparam logic [7:0] INT_BITS_MASK = 8'hEB;
  localparam logic [7:0] CAL_BITS_MASK = 8'hF0;
  localparam logic [7:0] SOFT_BITS_MASK = 8'h1F;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [6:0] RST_BUS_TARGET = 7'h6C;
  localparam logic [7:0] RST_INT_MASKS = 8'h35;
  localparam logic [7:0] RST_MASKS = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ****************************************************************
  // Bundled live alarm inputs from the detectors
  // ****************************************************************
  typedef struct packed {
    logic [1:0] aux_input_signal_lost;
    logic smbus_timeout;
    logic crystal_lock_error;
    logic crystal_signal_lost;
    logic calibrating_now;
    logic [3:0] out_of_frequency;
    logic [3:0] loss_of_signal;
    logic [3:0] pll_holdover;
    logic [3:0] pll_unlocked;
    logic [3:0] pll_calibrating;
  } ascp_alarms_t;

  // Register access request from the serial port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ascp_req_t;

endpackage : ascp_pkg

// *** rtl/ascp_regs.sv ***
`timescale 1ns/1ps
module ascp_regs
  import ascp_pkg::*;
#(
  parameter logic [15:0] PART_DIGITS = 16'h1234, // Arbitrary value
  parameter logic [7:0] SPEED_GRADE = 8'h00, // Arbitrary value
  parameter logic [7:0] SILICON_REV = 8'h00, // Arbitrary value
  parameter logic [23:0] IMAGE_VERSION = 24'h00_0000, // Arbitrary value
  parameter logic [7:0] TEMP_GRADE = 8'h00, // Arbitrary value
  parameter logic [7:0] PACKAGE_CODE = 8'h00 // Arbitrary value
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire ascp_req_t REQ,
  input wire ascp_alarms_t ALARMS,
  input wire logic DEVICE_READY,
  output logic [7:0] RDATA,
  output logic RVALID,
  output logic [7:0] PAGE,
  output logic [6:0] BUS_TARGET,
  output logic [7:0] HOLD_CFG,
  output logic SOFT_RESET_ALL,
  output logic [3:0] PLL_SOFT_RESET,
  output logic STEP_UP,
  output logic STEP_DOWN,
  output logic IRQ
);

  // ****************************************************************
  // Input synchronisers for alarm pins
  // ****************************************************************
  ascp_alarms_t alm_meta_q;
  ascp_alarms_t alm_q;
  logic rdy_meta_q;
  logic rdy_q;

  // Detectors sit in other domains, so two flops before any use
  always_ff @(posedge MCLK) begin
    alm_meta_q <= ALARMS;
    alm_q <= alm_meta_q;
    rdy_meta_q <= DEVICE_READY;
    rdy_q <= rdy_meta_q;
  end

  // ****************************************************************
  // Live status bytes
  // ****************************************************************
  logic [7:0] int_live;
  logic [7:0] input_live;
  logic [7:0] pll_live;
  logic [7:0] cal_live;
  // Bits 4 and 2 are unused and read as zero
  assign int_live = {alm_q.aux_input_signal_lost, alm_q.smbus_timeout, 1'b0,
                     alm_q.crystal_lock_error, 1'b0, alm_q.crystal_signal_lost, alm_q.calibrating_now};
  assign input_live = {alm_q.out_of_frequency, alm_q.loss_of_signal};
  assign pll_live = {alm_q.pll_holdover, alm_q.pll_unlocked};
  assign cal_live = {alm_q.pll_calibrating, 4'h0};

  logic wr_page0;
  logic wr_any;
  // Page zero registers only respond when page zero is selected
  assign wr_any = REQ.wr;
  assign wr_page0 = REQ.wr && (PAGE == RST_PAGE);

  // ****************************************************************
  // Page select and bus target address
  // ****************************************************************
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      PAGE <= RST_PAGE;
    end else if (wr_any && REQ.addr == ADDR_PAGE_SELECT) begin
      PAGE <= REQ.wdata;
    end
  end

  // Kept out of the NVM save image: the save logic never reads it
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      BUS_TARGET <= RST_BUS_TARGET;
    end else if (wr_page0 && REQ.addr == ADDR_BUS_TARGET) begin
      BUS_TARGET <= REQ.wdata[6:0];
    end
  end

  // Holdover configuration byte, plain storage of the low nibble; upper nibble reads zero
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      HOLD_CFG <= RST_ZERO;
    end else if (wr_page0 && REQ.addr == ADDR_HOLD_CFG) begin
      HOLD_CFG <= {4'h0, REQ.wdata[3:0]};
    end
  end

  // ****************************************************************
  // Sticky flags: set wins over a write of zero in the same cycle
  // ****************************************************************
  logic [7:0] int_flags_q;
  logic [7:0] input_flags_q;
  logic [7:0] pll_flags_q;
  logic [7:0] cal_flags_q;

  function automatic logic [7:0] sticky_next(
    input logic [7:0] cur,
    input logic [7:0] live,
    input logic hit,
    input logic [7:0] wdata,
    input logic [7:0] impl
  );
    logic [7:0] kept;
    kept = hit ? (cur & wdata) : cur;
    sticky_next = (kept | live) & impl;
  endfunction : sticky_next

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      int_flags_q <= RST_ZERO;
    end else begin
      int_flags_q <= sticky_next(int_flags_q, int_live, wr_page0 && REQ.addr == ADDR_INT_FLAGS,
                                 REQ.wdata, INT_BITS_MASK);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      input_flags_q <= RST_ZERO;
    end else begin
      input_flags_q <= sticky_next(input_flags_q, input_live, wr_page0 && REQ.addr == ADDR_INPUT_FLAGS,
                                   REQ.wdata, 8'hFF);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pll_flags_q <= RST_ZERO;
    end else begin
      pll_flags_q <= sticky_next(pll_flags_q, pll_live, wr_page0 && REQ.addr == ADDR_PLL_FLAGS,
                                 REQ.wdata, 8'hFF);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cal_flags_q <= RST_ZERO;
    end else begin
      cal_flags_q <= sticky_next(cal_flags_q, cal_live, wr_page0 && REQ.addr == ADDR_CAL_FLAGS,
                                 REQ.wdata, CAL_BITS_MASK);
    end
  end

  // ****************************************************************
  // Interrupt masks
  // ****************************************************************
  logic [7:0] int_masks_q;
  logic [7:0] input_masks_q;
  logic [7:0] pll_masks_q;
  logic [7:0] cal_masks_q;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      int_masks_q <= RST_INT_MASKS;
      input_masks_q <= RST_MASKS;
      pll_masks_q <= RST_MASKS;
      cal_masks_q <= RST_MASKS;
    end else if (wr_page0) begin
      if (REQ.addr == ADDR_INT_MASKS) begin
        int_masks_q <= REQ.wdata & INT_BITS_MASK;
      end else if (REQ.addr == ADDR_INPUT_MASKS) begin
        input_masks_q <= REQ.wdata;
      end else if (REQ.addr == ADDR_PLL_MASKS) begin
        pll_masks_q <= REQ.wdata;
      end else if (REQ.addr == ADDR_CAL_MASKS) begin
        cal_masks_q <= REQ.wdata & CAL_BITS_MASK;
      end
    end
  end

  // Registered so the pin never glitches while flags update
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(int_flags_q & ~int_masks_q)
           | |(input_flags_q & ~input_masks_q)
           | |(pll_flags_q & ~pll_masks_q)
           | |(cal_flags_q & ~cal_masks_q);
    end
  end

  // ****************************************************************
  // Self-clearing triggers: one-cycle pulses, register reads zero
  // ****************************************************************
  logic soft_hit;
  logic step_hit;
  logic [1:0] step_q;
  assign soft_hit = wr_page0 && REQ.addr == ADDR_SOFT_RESET;
  assign step_hit = wr_page0 && REQ.addr == ADDR_FREQ_STEP;

  // Reference PLL reset fans out to every PLL
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      SOFT_RESET_ALL <= 1'b0;
      PLL_SOFT_RESET <= 4'h0;
    end else begin
      SOFT_RESET_ALL <= soft_hit && REQ.wdata[BIT_SOFT_ALL];
      if (soft_hit && REQ.wdata[BIT_SOFT_REF_PLL]) begin
        PLL_SOFT_RESET <= 4'hF;
      end else if (soft_hit) begin
        PLL_SOFT_RESET <= REQ.wdata[4:1];
      end else begin
        PLL_SOFT_RESET <= 4'h0;
      end
    end
  end

  // Step bits remember only the previous cycle's write, so a 1 fires unless the write just before also set it
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      step_q <= 2'b00;
      STEP_UP <= 1'b0;
      STEP_DOWN <= 1'b0;
    end else begin
      step_q <= step_hit ? REQ.wdata[1:0] : 2'b00;
      STEP_UP <= step_hit && REQ.wdata[BIT_STEP_UP] && !step_q[BIT_STEP_UP];
      STEP_DOWN <= step_hit && REQ.wdata[BIT_STEP_DOWN] && !step_q[BIT_STEP_DOWN];
    end
  end

  // ****************************************************************
  // Read decode
  // ****************************************************************
  logic [7:0] rd_d;
  always_comb begin
    rd_d = 8'h00;
    if (REQ.addr == ADDR_PAGE_SELECT) begin
      rd_d = PAGE;
    end else if (REQ.addr == ADDR_DEVICE_READY) begin
      rd_d = {7'h00, rdy_q};
    end else if (PAGE != RST_PAGE) begin
      rd_d = 8'h00;
    end else if (REQ.addr == ADDR_PART_LOW) begin
      rd_d = PART_DIGITS[7:0];
    end else if (REQ.addr == ADDR_PART_HIGH) begin
      rd_d = PART_DIGITS[15:8];
    end else if (REQ.addr == ADDR_SPEED_GRADE) begin
      rd_d = SPEED_GRADE;
    end else if (REQ.addr == ADDR_SILICON_REV) begin
      rd_d = SILICON_REV;
    end else if (REQ.addr == ADDR_IMAGE_LOW) begin
      rd_d = IMAGE_VERSION[7:0];
    end else if (REQ.addr == ADDR_IMAGE_MINOR) begin
      rd_d = IMAGE_VERSION[15:8];
    end else if (REQ.addr == ADDR_IMAGE_HIGH) begin
      rd_d = IMAGE_VERSION[23:16];
    end else if (REQ.addr == ADDR_TEMP_GRADE) begin
      rd_d = TEMP_GRADE;
    end else if (REQ.addr == ADDR_PACKAGE_CODE) begin
      rd_d = PACKAGE_CODE;
    end else if (REQ.addr == ADDR_BUS_TARGET) begin
      rd_d = {1'b0, BUS_TARGET};
    end else if (REQ.addr == ADDR_INT_STATUS) begin
      rd_d = int_live;
    end else if (REQ.addr == ADDR_INPUT_STATUS) begin
      rd_d = input_live;
    end else if (REQ.addr == ADDR_PLL_STATUS) begin
      rd_d = pll_live;
    end else if (REQ.addr == ADDR_CAL_STATUS) begin
      rd_d = cal_live;
    end else if (REQ.addr == ADDR_INT_FLAGS) begin
      rd_d = int_flags_q;
    end else if (REQ.addr == ADDR_INPUT_FLAGS) begin
      rd_d = input_flags_q;
    end else if (REQ.addr == ADDR_PLL_FLAGS) begin
      rd_d = pll_flags_q;
    end else if (REQ.addr == ADDR_CAL_FLAGS) begin
      rd_d = cal_flags_q;
    end else if (REQ.addr == ADDR_HOLD_CFG) begin
      rd_d = HOLD_CFG;
    end else if (REQ.addr == ADDR_INT_MASKS) begin
      rd_d = int_masks_q;
    end else if (REQ.addr == ADDR_INPUT_MASKS) begin
      rd_d = input_masks_q;
    end else if (REQ.addr == ADDR_PLL_MASKS) begin
      rd_d = pll_masks_q;
    end else if (REQ.addr == ADDR_CAL_MASKS) begin
      rd_d = cal_masks_q;
    end
  end

  // Read data registered one cycle after the request
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      RDATA <= RST_ZERO;
      RVALID <= 1'b0;
    end else begin
      RDATA <= REQ.rd ? rd_d : RDATA;
      RVALID <= REQ.rd;
    end
  end

endmodule : ascp_regs

// *** test/ascp_regs_props.sv ***
`timescale 1ns/1ps
module ascp_regs_props
  import ascp_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire ascp_req_t REQ,
  input wire logic [7:0] RDATA,
  input wire logic RVALID,
  input wire logic [7:0] PAGE,
  input wire logic [6:0] BUS_TARGET,
  input wire logic SOFT_RESET_ALL,
  input wire logic [3:0] PLL_SOFT_RESET,
  input wire logic STEP_UP,
  input wire logic STEP_DOWN
);
  // ****************************************
  // Decoded page-zero writes
  // ****************************************
  logic pg0, wr_rst, up_wr, dn_wr, step_wr;
  assign pg0 = (PAGE == RST_PAGE);
  assign wr_rst = REQ.wr && pg0 && (REQ.addr == ADDR_SOFT_RESET);
  assign step_wr = REQ.wr && pg0 && (REQ.addr == ADDR_FREQ_STEP);
  assign up_wr = step_wr && REQ.wdata[BIT_STEP_UP];
  assign dn_wr = step_wr && REQ.wdata[BIT_STEP_DOWN];

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // Only a fresh write is an edge; a repeat in the next cycle is not
  sequence s_up_new; !up_wr ##1 up_wr; endsequence
  sequence s_dn_new; !dn_wr ##1 dn_wr; endsequence

  a_read_answer: assert property (REQ.rd |=> RVALID)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (RVALID |-> $past(REQ.rd))
    else $error("read valid without a read");
  a_page_write: assert property (REQ.wr && REQ.addr == ADDR_PAGE_SELECT |=> PAGE == $past(REQ.wdata))
    else $error("page write not taken");
  a_page_read: assert property (REQ.rd && REQ.addr == ADDR_PAGE_SELECT |=> RDATA == $past(PAGE))
    else $error("page read wrong");
  a_other_page: assert property (REQ.rd && !pg0 && REQ.addr != ADDR_PAGE_SELECT
    && REQ.addr != ADDR_DEVICE_READY |=> RDATA == 8'h00)
    else $error("read on other page not zero");
  a_target_write: assert property (REQ.wr && pg0 && REQ.addr == ADDR_BUS_TARGET
    |=> BUS_TARGET == $past(REQ.wdata[6:0]))
    else $error("target address not written");
  a_soft_all: assert property (wr_rst |=> SOFT_RESET_ALL == $past(REQ.wdata[BIT_SOFT_ALL]))
    else $error("device reset pulse wrong");
  a_soft_cause: assert property (SOFT_RESET_ALL |-> $past(wr_rst))
    else $error("device reset pulse without write");
  a_ref_pll_all: assert property (wr_rst && REQ.wdata[BIT_SOFT_REF_PLL] |=> PLL_SOFT_RESET == 4'hF)
    else $error("reference pll reset not on all");
  a_pll_a_only: assert property (wr_rst && REQ.wdata[4:0] == 5'h02
    |=> PLL_SOFT_RESET == 4'h1 && !SOFT_RESET_ALL)
    else $error("pll a reset spread");
  a_step_up: assert property (s_up_new |=> STEP_UP)
    else $error("step up missing");
  a_step_down: assert property (s_dn_new |=> STEP_DOWN)
    else $error("step down missing");
  a_step_cause: assert property (STEP_UP || STEP_DOWN |-> $past(step_wr))
    else $error("step without write");
endmodule : ascp_regs_props

bind ascp_regs ascp_regs_props ascp_regs_props_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .REQ(REQ),
  .RDATA(RDATA), .RVALID(RVALID), .PAGE(PAGE), .BUS_TARGET(BUS_TARGET), .SOFT_RESET_ALL(SOFT_RESET_ALL),
  .PLL_SOFT_RESET(PLL_SOFT_RESET), .STEP_UP(STEP_UP), .STEP_DOWN(STEP_DOWN));

// *** test/ascp_regs_tb.sv ***
`timescale 1ns/1ps
module ascp_regs_tb;
  import ascp_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  ascp_req_t req = '0;
  ascp_alarms_t alarms = '0;
  logic dev_ready = 1'b1;
  logic [7:0] rdata, page, hold_cfg;
  logic rvalid, soft_all, step_up, step_dn, irq;
  logic [6:0] bus_target;
  logic [3:0] pll_rst;
  int err_total = 0;
  int comparisons = 0;

  // Free-running 100 MHz clock
  always #5 mclk = ~mclk;

  // Identity values are arbitrary
  ascp_regs #(.PART_DIGITS(16'h5678), .SPEED_GRADE(8'h03), .SILICON_REV(8'h01),
    .IMAGE_VERSION(24'h12_3456)) ascp_regs_i (.MCLK(mclk), .SYS_RST(sys_rst), .REQ(req),
    .ALARMS(alarms), .DEVICE_READY(dev_ready), .RDATA(rdata), .RVALID(rvalid), .PAGE(page),
    .BUS_TARGET(bus_target), .HOLD_CFG(hold_cfg), .SOFT_RESET_ALL(soft_all),
    .PLL_SOFT_RESET(pll_rst), .STEP_UP(step_up), .STEP_DOWN(step_dn), .IRQ(irq));

  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One request, held for one edge; returns just after the answer lands
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk) req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: d};
    #1;
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd(ADDR_PAGE_SELECT, 8'h00);
    rd(ADDR_BUS_TARGET, 8'h6C);
    rd(ADDR_INT_MASKS, 8'h35);
    rd(ADDR_INPUT_MASKS, 8'h00);
    rd(ADDR_PLL_MASKS, 8'h00);
    rd(ADDR_CAL_MASKS, 8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_ident;
    rd(ADDR_PART_LOW, 8'h78);
    rd(ADDR_PART_HIGH, 8'h56);
    rd(ADDR_SPEED_GRADE, 8'h03);
    rd(ADDR_SILICON_REV, 8'h01);
    rd(ADDR_IMAGE_LOW, 8'h56);
    rd(ADDR_IMAGE_MINOR, 8'h34);
    rd(ADDR_IMAGE_HIGH, 8'h12);
    rd(ADDR_TEMP_GRADE, 8'h00);
    rd(ADDR_PACKAGE_CODE, 8'h00);
    $display("t_ident done");
  endtask : t_ident

  // Foreign page hides page zero, but selector and ready stay visible
  task automatic t_page;
    xfer(1'b1, ADDR_PAGE_SELECT, 8'h05);
    chk(page, 8'h05);
    rd(ADDR_PAGE_SELECT, 8'h05);
    rd(ADDR_BUS_TARGET, 8'h00);
    xfer(1'b1, ADDR_BUS_TARGET, 8'h11);
    rd(ADDR_DEVICE_READY, 8'h01);
    // Ready low must read back as zero, so the bit is really live
    @(posedge mclk) dev_ready <= 1'b0;
    settle(4);
    rd(ADDR_DEVICE_READY, 8'h00);
    @(posedge mclk) dev_ready <= 1'b1;
    settle(4);
    xfer(1'b1, ADDR_PAGE_SELECT, 8'h00);
    rd(ADDR_BUS_TARGET, 8'h6C);
    xfer(1'b1, ADDR_BUS_TARGET, 8'hAA);
    chk({1'b0, bus_target}, 8'h2A);
    rd(ADDR_BUS_TARGET, 8'h2A);
    // Holdover configuration keeps only its low nibble
    xfer(1'b1, ADDR_HOLD_CFG, 8'hFF);
    chk(hold_cfg, 8'h0F);
    rd(ADDR_HOLD_CFG, 8'h0F);
    $display("t_page done");
  endtask : t_page

  // Each trigger bit alone; reference PLL bit fans out to all four
  task automatic t_trig;
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, ADDR_SOFT_RESET, 8'h01 << i);
      chk({3'h0, pll_rst, soft_all}, (i == 2) ? 8'h1E : 8'h01 << i);
    end
    xfer(1'b1, ADDR_SOFT_RESET, 8'h00);
    chk({3'h0, pll_rst, soft_all}, 8'h00);
    rd(ADDR_SOFT_RESET, 8'h00);
    xfer(1'b1, ADDR_FREQ_STEP, 8'h01);
    chk({6'h00, step_dn, step_up}, 8'h01);
    xfer(1'b1, ADDR_FREQ_STEP, 8'h02);
    chk({6'h00, step_dn, step_up}, 8'h02);
    $display("t_trig done");
  endtask : t_trig

  task automatic t_alarm;
    // Aux 10, timeout, crystal lost, LOSS_OF_SIGNAL 5, OUT_OF_FREQUENCY A, unlock 3, hold C, cal 9
    @(posedge mclk) alarms <= 26'h2AA_5C39;
    settle(6);
    rd(ADDR_INT_STATUS, 8'hA2);
    rd(ADDR_INPUT_STATUS, 8'hA5);
    rd(ADDR_PLL_STATUS, 8'hC3);
    rd(ADDR_CAL_STATUS, 8'h90);
    @(posedge mclk) alarms <= '0;
    settle(6);
    rd(ADDR_INPUT_STATUS, 8'h00);
    rd(ADDR_INT_FLAGS, 8'hA2);
    rd(ADDR_INPUT_FLAGS, 8'hA5);
    rd(ADDR_PLL_FLAGS, 8'hC3);
    rd(ADDR_CAL_FLAGS, 8'h90);
    chk({7'h00, irq}, 8'h01);
    for (int a = 8'h17; a <= 8'h1A; a++) begin
      xfer(1'b1, a[7:0], 8'hFF);
    end
    settle(2);
    chk({7'h00, irq}, 8'h00);
    rd(ADDR_CAL_MASKS, 8'hF0);
    xfer(1'b1, ADDR_INPUT_MASKS, 8'h00);
    settle(2);
    chk({7'h00, irq}, 8'h01);
    xfer(1'b1, ADDR_INT_FLAGS, 8'hA0);
    rd(ADDR_INT_FLAGS, 8'hA0);
    xfer(1'b1, ADDR_INPUT_FLAGS, 8'h00);
    rd(ADDR_INPUT_FLAGS, 8'h00);
    settle(2);
    chk({7'h00, irq}, 8'h00);
    $display("t_alarm done");
  endtask : t_alarm

  // ****************************************
  // Verdict, watchdog and main sequence
  // ****************************************
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // Whole run needs under 150 cycles; a hang ends well after that
  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_ident();
    t_page();
    t_trig();
    t_alarm();
    report_and_stop();
  end
endmodule : ascp_regs_tb
